// ---- hdl/lan_coproc_bus_glue.sv ----
// arbiter, strobe converter and ready generator joining a lan coprocessor to a dram local bus
// assumes core_clk is the inverted cpu clock and the coprocessor runs on the same clock
// Function
// - arbiter synchronous on inverted cpu clock
// - fixed priority; requests bus from cpu
// - drive bus request and grant acknowledge
// - wait out dram precharge before handover
// - converted controls float unless coprocessor owns bus
// - strobes, read/write, buffer enable from coprocessor
// - 32-bit: size and low address from enables
// - 16-bit: byte strobes from enables, a1 passed through
// - cycle starts buffer address status when owning
// - transfers last two clocks minimum
// - wait states hold ready deasserted
// - multiple cycle is repeated single transfers
// - burst at most four beats, one status
// - ready and burst ready at right clocks
// - non-burst variants get single transfers only
// - registered address status gives emulated strobe
// - emulated strobe held in second clock
// - delay ready for read data setup
// - extra read wait states when needed
// - refresh first, coprocessor second, cpu last
// - hold grant is inverse of ownership
// - request, grant, acknowledge, release ordering
`timescale 1ns/1ns
module lan_coproc_bus_glue import lan_glue_pkg::*; #(
    parameter bit         BUS32      = 1'b1,           // 32-bit coprocessor, else 16-bit
    parameter bit         BURST_EN   = 1'b1,           // coprocessor variant supports bursts
    parameter logic [2:0] WAIT_CLKS  = WAIT_CLKS_DEF,  // wait states on a first beat
    parameter logic [2:0] READ_EXTRA = READ_EXTRA_DEF  // further wait states on reads
) (
    input  wire logic       core_clk,            // inverted cpu clock
    input  wire logic       nrst,                // asynchronous reset, active low
    input  wire logic       refresh_req,         // asynchronous refresh request
    input  wire logic       refresh_done,        // memory controller ends refresh
    input  wire logic       hold_req,            // coprocessor bus hold request
    input  wire logic       cpu_bus_grant_n,     // cpu bus grant pin
    output logic            cpu_bus_req_n,       // bus request to cpu
    output logic            grant_ack_n,         // grant acknowledge to cpu
    output logic            hold_grant,          // hold acknowledge to coprocessor
    output logic            coproc_owns_bus_n,   // coprocessor is bus master
    output logic            refresh_cycle,       // refresh owns the bus
    input  wire logic       addr_status_n,       // coprocessor address status
    input  wire logic       wr_rd,               // coprocessor write high, read low
    input  wire logic [3:0] byte_enables_n,      // 32-bit byte enables
    input  wire logic       addr_bit1_in,        // 16-bit coprocessor address bit 1
    input  wire logic       high_byte_en_n,      // 16-bit high byte enable
    input  wire logic       low_byte_en_n,       // 16-bit low byte enable
    input  wire logic       last_beat_n,         // coprocessor last beat
    output cpu_ctrl_s       cpu_ctrl,            // converted cpu controls
    output logic            cpu_ctrl_oe,         // drive enable for cpu_ctrl
    output logic            ext_cycle_start_n,   // emulated external cycle start
    output logic            op_cycle_start_n,    // emulated operating cycle start
    output logic            cycle_start_oe,      // drive enable for cycle starts
    output logic            ready_n,             // ready to coprocessor
    output logic            burst_ready_n        // burst ready to coprocessor
);

    // synchronised pins
    logic [1:0] sync_lvl;    // {grant_n, refresh}
    logic       refresh_s;   // synchronised refresh request
    logic       grant_s_n;   // synchronised cpu grant

    // the refresh request and cpu grant come from other timing
    pin_sync3 #(
        .W    (2),
        .INIT (SYNC_INIT)
    ) u_sync (
        .clk      (core_clk),
        .rst_n    (nrst),
        .pin_in   ({cpu_bus_grant_n, refresh_req}),
        .sync_out (sync_lvl)
    );

    assign refresh_s = sync_lvl[0];
    assign grant_s_n = sync_lvl[1];

    // arbiter state
    arb_state_e state_reg, state_next;  // arbiter state
    logic       br_reg, br_next;        // bus request, active low
    logic       ack_reg, ack_next;      // grant acknowledge, active low
    logic       own_reg, own_next;      // coprocessor owns bus, active low
    logic       rfc_reg, rfc_next;      // refresh cycle
    logic [3:0] pre_reg, pre_next;      // precharge countdown

    // transfer state
    logic       act_reg, act_next;      // transfer in progress
    logic [2:0] cnt_reg, cnt_next;      // wait clocks left in the beat
    logic [1:0] beat_reg, beat_next;    // beat index within a burst
    cpu_ctrl_s  ctrl_reg, ctrl_next;    // converted controls
    logic       start;                  // address status seen while owning
    logic       beat_end;               // this clock ends a beat
    logic       burst_go;               // end the beat with burst ready
    logic [2:0] first_wait;             // wait clocks for a new transfer

    // byte enables to size and lowest address
    function automatic logic [3:0] be_decode(input logic [3:0] be_n);
        logic [2:0] n;
        logic [1:0] low;
        n   = 3'h0;
        low = 2'h0;
        for (int i = 3; i >= 0; i--) begin
            if (!be_n[i]) begin
                n   = n + 3'h1;
                low = 2'(i);
            end
        end
        return {n[1:0], low};   // four bytes give size 00
    endfunction

    // arbiter next state, fixed priority through the cpu handshake
    always_comb begin
        state_next = state_reg;
        br_next    = br_reg;
        ack_next   = ack_reg;
        own_next   = own_reg;
        rfc_next   = rfc_reg;
        pre_next   = (pre_reg != 4'h0) ? pre_reg - 4'h1 : pre_reg;
        case (state_reg)
            ARB_IDLE: begin
                // any requester asks the cpu for the bus
                if (refresh_s || hold_req) begin
                    br_next    = 1'b0;
                    state_next = ARB_WAIT_GRANT;
                end
            end
            ARB_WAIT_GRANT: begin
                // acknowledge the grant, cpu access just ended
                if (!grant_s_n) begin
                    ack_next   = 1'b0;
                    pre_next   = PRE_CNT_W_CLKS;
                    state_next = ARB_PICK;
                end
            end
            ARB_PICK: begin
                // hand over only once precharge is over
                if (pre_reg == 4'h0) begin
                    if (refresh_s) begin
                        rfc_next   = 1'b1;      // refresh first
                        state_next = ARB_REFRESH;
                    end else if (hold_req) begin
                        own_next   = 1'b0;      // coprocessor second
                        state_next = ARB_COPROC;
                    end else begin
                        br_next    = 1'b1;      // give back to cpu
                        state_next = ARB_RELEASE;
                    end
                end
            end
            ARB_REFRESH: begin
                // bus request stays low into the next owner
                if (refresh_done) begin
                    rfc_next   = 1'b0;
                    pre_next   = PRE_CNT_W_CLKS;
                    state_next = ARB_PICK;
                end
            end
            ARB_COPROC: begin
                // a refresh waits until the coprocessor lets go
                if (!hold_req && !act_reg) begin
                    own_next   = 1'b1;
                    pre_next   = PRE_CNT_W_CLKS;
                    state_next = ARB_PICK;
                end
            end
            ARB_RELEASE: begin
                // acknowledge is released only after the grant is withdrawn
                if (grant_s_n) begin
                    ack_next   = 1'b1;
                    state_next = ARB_IDLE;
                end
            end
            default: begin
                state_next = ARB_IDLE;
            end
        endcase
    end

    // arbiter registers, idle and released after reset
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= ARB_IDLE;
            br_reg    <= 1'b1;
            ack_reg   <= 1'b1;
            own_reg   <= 1'b1;
            rfc_reg   <= 1'b0;
            pre_reg   <= 4'h0;
        end else begin
            state_reg <= state_next;
            br_reg    <= br_next;
            ack_reg   <= ack_next;
            own_reg   <= own_next;
            rfc_reg   <= rfc_next;
            pre_reg   <= pre_next;
        end
    end

    assign cpu_bus_req_n     = br_reg;
    assign grant_ack_n       = ack_reg;
    assign coproc_owns_bus_n = own_reg;
    assign refresh_cycle     = rfc_reg;
    assign hold_grant        = !own_reg;

    // transfer decode; coprocessor opens each cycle with address status
    assign start      = !own_reg && !addr_status_n && !act_reg;
    assign first_wait = 3'(WAIT_CLKS + (wr_rd ? 3'h0 : READ_EXTRA));
    assign beat_end   = act_reg && (cnt_reg == 3'h0);
    // burst continues while last beat is high in the beat, up to the fourth beat, 32-bit burst variant only
    assign burst_go   = BUS32 && BURST_EN && last_beat_n && (beat_reg != LAST_BURST_BEAT);

    // transfer and converter next state
    always_comb begin
        act_next  = act_reg;
        cnt_next  = cnt_reg;
        beat_next = beat_reg;
        ctrl_next = ctrl_reg;
        if (beat_end) begin
            if (burst_go) begin
                beat_next = beat_reg + 2'h1;    // next beat in one clock
                cnt_next  = 3'h0;
            end else begin
                act_next  = 1'b0;               // transfer done, single or final burst beat
                ctrl_next = CTRL_IDLE;
            end
        end else if (act_reg) begin
            cnt_next = cnt_reg - 3'h1;          // wait state, ready held off
        end else if (start) begin
            // registered address status opens the emulated strobe
            act_next                = 1'b1;
            cnt_next                = first_wait;
            beat_next               = 2'h0;
            ctrl_next               = CTRL_IDLE;
            ctrl_next.addr_strobe_n = 1'b0;
            ctrl_next.data_strobe_n = 1'b0;
            ctrl_next.data_buf_en_n = 1'b0;
            ctrl_next.rd_wr         = !wr_rd;
            if (BUS32) begin
                {ctrl_next.xfer_size1, ctrl_next.xfer_size0,
                 ctrl_next.addr_bit1, ctrl_next.addr_bit0} = be_decode(byte_enables_n);
            end else begin
                ctrl_next.addr_bit1           = addr_bit1_in;
                ctrl_next.upper_byte_strobe_n = high_byte_en_n;
                ctrl_next.lower_byte_strobe_n = low_byte_en_n;
            end
        end
    end

    // transfer registers
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            act_reg  <= 1'b0;
            cnt_reg  <= 3'h0;
            beat_reg <= 2'h0;
            ctrl_reg <= CTRL_IDLE;
        end else begin
            act_reg  <= act_next;
            cnt_reg  <= cnt_next;
            beat_reg <= beat_next;
            ctrl_reg <= ctrl_next;
        end
    end

    // converted controls and cycle starts float unless the coprocessor owns the bus; readies always driven
    assign cpu_ctrl          = ctrl_reg;
    assign cpu_ctrl_oe       = !own_reg;
    assign ext_cycle_start_n = addr_status_n;
    assign op_cycle_start_n  = addr_status_n;
    assign cycle_start_oe    = !own_reg;
    // ready ends the last beat; burst ready ends each beat that more beats follow
    assign ready_n           = !(beat_end && !burst_go);
    assign burst_ready_n     = !(beat_end && burst_go);

    // checking
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    logic [3:0] since_reg;   // clocks since transfer start, for checking
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            since_reg <= 4'h0;
        end else begin
            since_reg <= start ? 4'h0 : since_reg + 4'h1;
        end
    end

    chk_req_on_demand: assert property (
        (state_reg == ARB_IDLE && (refresh_s || hold_req)) |=> !cpu_bus_req_n)
        else $error("bus request not raised for a requester");
    chk_ack_after_grant: assert property (
        $fell(grant_ack_n) |-> !$past(grant_s_n) && !cpu_bus_req_n)
        else $error("acknowledge without grant");
    chk_ack_release: assert property (
        $rose(grant_ack_n) |-> cpu_bus_req_n && $past(grant_s_n))
        else $error("acknowledge released out of order");
    chk_precharge_gap: assert property (
        ($rose(refresh_cycle) || $fell(coproc_owns_bus_n)) |-> $past(pre_reg) == 4'h0)
        else $error("handover before precharge elapsed");
    chk_refresh_first: assert property (
        (state_reg == ARB_PICK && pre_reg == 4'h0 && refresh_s) |=> refresh_cycle && coproc_owns_bus_n)
        else $error("refresh lost priority");
    chk_owner_acked: assert property (
        cpu_ctrl_oe |-> !grant_ack_n && !cpu_bus_req_n && !refresh_cycle)
        else $error("converter drives without bus ownership");
    chk_hold_owner: assert property (
        $rose(hold_grant) |-> $past(state_reg) == ARB_PICK && $past(hold_req))
        else $error("hold grant without request");
    chk_two_clocks: assert property (
        start |-> ready_n && burst_ready_n ##1 !cpu_ctrl.addr_strobe_n)
        else $error("ready in first clock or strobe missing");
    chk_wait_count: assert property (
        (beat_end && beat_reg == 2'h0) |-> since_reg == 4'(WAIT_CLKS + (ctrl_reg.rd_wr ? READ_EXTRA : 3'h0)))
        else $error("first beat wait count wrong");
    chk_burst_limit: assert property (
        !burst_ready_n |-> beat_reg != LAST_BURST_BEAT && last_beat_n)
        else $error("burst beyond four beats");
    chk_no_burst_variant: assert property (
        !(BUS32 && BURST_EN) |-> burst_ready_n)
        else $error("burst ready on non-burst variant");
    chk_strobe_end: assert property (
        !ready_n |=> cpu_ctrl.addr_strobe_n && !act_reg)
        else $error("strobe not released after ready");

endmodule

// ---- hdl/lan_glue_pkg.sv ----
// constants, state enums and carrier struct for the coprocessor bus glue
// assumes a single 125 MHz arbitration clock shared by arbiter and ready logic
package lan_glue_pkg;

    localparam int CLK_MHZ        = 125;                                   // arbitration clock rate
    localparam int PRECHARGE_NS   = 60;                                    // dram precharge, least time
    localparam int PRECHARGE_CLKS = (PRECHARGE_NS * CLK_MHZ + 999) / 1000; // rounded up to clocks

    localparam logic [3:0] PRE_CNT_W_CLKS = 4'(PRECHARGE_CLKS);            // counter load value
    localparam logic [2:0] WAIT_CLKS_DEF  = 3'h0;                          // extra clocks per first beat
    localparam logic [2:0] READ_EXTRA_DEF = 3'h1;                          // extra clocks on every read
    localparam logic [1:0] LAST_BURST_BEAT = 2'h3;                         // fourth beat index
    localparam logic [1:0] SYNC_INIT      = 2'h2;                          // {grant_n idle high, refresh low}

    // arbiter states
    typedef enum logic [2:0] {
        ARB_IDLE,
        ARB_WAIT_GRANT,
        ARB_PICK,
        ARB_REFRESH,
        ARB_COPROC,
        ARB_RELEASE
    } arb_state_e;

    // converted cpu-style bus controls, strobes and buffer enable active low, rd_wr high = read
    typedef struct packed {
        logic addr_strobe_n;        // cpu address strobe
        logic data_strobe_n;        // cpu data strobe
        logic rd_wr;                // cpu read/write
        logic data_buf_en_n;        // data buffer enable
        logic xfer_size1;           // transfer size high
        logic xfer_size0;           // transfer size low
        logic addr_bit1;            // address bit 1
        logic addr_bit0;            // address bit 0
        logic upper_byte_strobe_n;  // 16-bit upper strobe
        logic lower_byte_strobe_n;  // 16-bit lower strobe
    } cpu_ctrl_s;

    localparam cpu_ctrl_s CTRL_IDLE = '1;                                  // strobes off, read

endpackage

// ---- hdl/pin_sync3.sv ----
// three-stage synchroniser for pins that arrive from outside the clock domain
// the output follows only once the second and third stages agree
`timescale 1ns/1ns
module pin_sync3 import lan_glue_pkg::*; #(
    parameter int           W    = 2,     // number of bits
    parameter logic [W-1:0] INIT = '0     // value held during reset
) (
    input  wire logic         clk,        // sampling clock
    input  wire logic         rst_n,      // asynchronous reset, active low
    input  wire logic [W-1:0] pin_in,     // raw asynchronous input
    output logic      [W-1:0] sync_out    // filtered synchronous level
);

    logic [W-1:0] s1_reg;   // first stage, read only by s2
    logic [W-1:0] s2_reg;   // second stage
    logic [W-1:0] s3_reg;   // third stage
    logic [W-1:0] out_next; // next filtered value
    logic [W-1:0] out_reg;  // filtered value

    // a bit changes only when the last two stages agree
    always_comb begin
        for (int i = 0; i < W; i++) begin
            out_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : out_reg[i];
        end
    end

    // shift chain and filtered output
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_reg  <= INIT;
            s2_reg  <= INIT;
            s3_reg  <= INIT;
            out_reg <= INIT;
        end else begin
            s1_reg  <= pin_in;
            s2_reg  <= s1_reg;
            s3_reg  <= s2_reg;
            out_reg <= out_next;
        end
    end

    assign sync_out = out_reg;

endmodule

// ---- tb/cpu_bus_model.sv ----
// stand-in for the cpu arbitration pins and the dram refresh controller
// assumes the glue's clock; grant follows a held request after a fixed lag
`timescale 1ns/1ns
module cpu_bus_model #(
    parameter int GRANT_LAG   = 2,     // grant comes once the request is held longer than this many clocks
    parameter int REFRESH_LEN = 6      // clocks a refresh lasts
) (
    input  wire logic core_clk,        // arbitration clock
    input  wire logic nrst,            // asynchronous reset, active low
    input  wire logic cpu_bus_req_n,   // bus request from the glue
    input  wire logic refresh_cycle,   // refresh owns the bus
    output logic      cpu_bus_grant_n, // grant to the glue
    output logic      refresh_done     // refresh finished, one pulse
);
    int req_cnt;                       // clocks the request has been held
    int ref_cnt;                       // clocks into the refresh
    // grant after a lag, withdraw as soon as the request drops
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            req_cnt = 0;
            ref_cnt = 0;
            cpu_bus_grant_n <= 1'b1;
            refresh_done <= 1'b0;
        end else begin
            req_cnt = cpu_bus_req_n ? 0 : req_cnt + 1;
            ref_cnt = refresh_cycle ? ref_cnt + 1 : 0;
            cpu_bus_grant_n <= #1 !(req_cnt > GRANT_LAG);
            refresh_done <= #1 (ref_cnt == REFRESH_LEN);
        end
    end
endmodule

// ---- tb/tb_top.sv ----
// self-checking bench for the coprocessor bus glue, 32-bit burst and 16-bit plain variants
// assumes cpu_bus_model plays the cpu arbitration and the refresh controller
`timescale 1ns/1ns
module tb_top import lan_glue_pkg::*;;
    typedef struct packed {
        logic       wr;                // write high
        logic [3:0] be;                // byte enables, active low
        logic [1:0] size;              // expected size lines
        logic [1:0] addr;              // expected low address bits
    } row_s;
    logic       core_clk = 1'b0;       // arbitration clock
    logic       nrst = 1'b0;           // reset, active low
    logic       refresh_req = 1'b0;    // refresh request
    logic       hold_req = 1'b0;       // coprocessor hold request
    logic       addr_status_n = 1'b1;  // address status
    logic       wr_rd = 1'b0;          // write high, read low
    logic [3:0] byte_enables_n = 4'hf; // byte enables
    logic       last_beat_n = 1'b0;    // last beat marker
    logic       refresh_done, cpu_bus_grant_n, cpu_bus_req_n, grant_ack_n, hold_grant;
    logic       coproc_owns_bus_n, refresh_cycle, cpu_ctrl_oe, cycle_start_oe;
    logic       ext_cycle_start_n, op_cycle_start_n, ready_n, burst_ready_n;
    cpu_ctrl_s  cpu_ctrl;              // converted controls
    cpu_ctrl_s  ctrl16;                // converted controls, 16-bit variant
    logic       ready16_n, burst16_n;  // readies, 16-bit variant
    int         errors = 0;            // mismatches
    int         checks_done = 0;       // comparisons
    int         cycles = 0;            // timeout counter
    int         n;                     // wait counter
    row_s       rows[6] = '{'{1'b1, 4'he, 2'h1, 2'h0}, '{1'b0, 4'h0, 2'h0, 2'h0}, '{1'b1, 4'hd, 2'h1, 2'h1},
                            '{1'b0, 4'h3, 2'h2, 2'h2}, '{1'b1, 4'h7, 2'h1, 2'h3}, '{1'b0, 4'h8, 2'h3, 2'h0}};

    lan_coproc_bus_glue u_dut (.core_clk(core_clk), .nrst(nrst), .refresh_req(refresh_req),
        .refresh_done(refresh_done), .hold_req(hold_req), .cpu_bus_grant_n(cpu_bus_grant_n),
        .cpu_bus_req_n(cpu_bus_req_n), .grant_ack_n(grant_ack_n), .hold_grant(hold_grant),
        .coproc_owns_bus_n(coproc_owns_bus_n), .refresh_cycle(refresh_cycle), .addr_status_n(addr_status_n),
        .wr_rd(wr_rd), .byte_enables_n(byte_enables_n), .addr_bit1_in(1'b0), .high_byte_en_n(1'b0),
        .low_byte_en_n(1'b0), .last_beat_n(last_beat_n), .cpu_ctrl(cpu_ctrl), .cpu_ctrl_oe(cpu_ctrl_oe),
        .ext_cycle_start_n(ext_cycle_start_n), .op_cycle_start_n(op_cycle_start_n),
        .cycle_start_oe(cycle_start_oe), .ready_n(ready_n), .burst_ready_n(burst_ready_n));
    // 16-bit variant in lockstep; its lane inputs ride on the byte enables
    lan_coproc_bus_glue #(.BUS32(1'b0), .BURST_EN(1'b0)) u_dut16 (.core_clk(core_clk), .nrst(nrst),
        .refresh_req(refresh_req), .refresh_done(refresh_done), .hold_req(hold_req),
        .cpu_bus_grant_n(cpu_bus_grant_n), .cpu_bus_req_n(), .grant_ack_n(), .hold_grant(),
        .coproc_owns_bus_n(), .refresh_cycle(), .addr_status_n(addr_status_n), .wr_rd(wr_rd),
        .byte_enables_n(byte_enables_n), .addr_bit1_in(byte_enables_n[3]), .high_byte_en_n(byte_enables_n[1]),
        .low_byte_en_n(byte_enables_n[0]), .last_beat_n(last_beat_n), .cpu_ctrl(ctrl16), .cpu_ctrl_oe(),
        .ext_cycle_start_n(), .op_cycle_start_n(), .cycle_start_oe(), .ready_n(ready16_n),
        .burst_ready_n(burst16_n));
    cpu_bus_model u_cpu (.core_clk(core_clk), .nrst(nrst), .cpu_bus_req_n(cpu_bus_req_n),
        .refresh_cycle(refresh_cycle), .cpu_bus_grant_n(cpu_bus_grant_n), .refresh_done(refresh_done));

    // clock and hang guard
    always #4 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            results();
        end
    end
    // ownership outputs must track each other every cycle
    always @(negedge core_clk) begin
        if (nrst === 1'b1) begin
            cmp_bit("hold_inverse", !coproc_owns_bus_n, hold_grant);
            cmp_bit("ctrl_oe", hold_grant, cpu_ctrl_oe);
            cmp_bit("start_oe", hold_grant, cycle_start_oe);
        end
    end

    task automatic cmp_bit(input string what, input logic exp, input logic got);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic cmp_fld(input string what, input logic [1:0] exp, input logic [1:0] got);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic step;
        @(posedge core_clk);
        #1;
    endtask
    task automatic chk_idle;
        cmp_bit("req_idle", 1'b1, cpu_bus_req_n);
        cmp_bit("ack_idle", 1'b1, grant_ack_n);
        cmp_bit("hold_idle", 1'b0, hold_grant);
        cmp_bit("ready_idle", 1'b1, ready_n);
        cmp_bit("ctrl_idle", 1'b1, cpu_ctrl === CTRL_IDLE);
    endtask
    // one transfer from address status to final ready, optionally a four-beat burst
    task automatic xfer(input logic wr, input logic [3:0] be, input logic [1:0] size, input logic [1:0] addr,
                        input bit burst);
        int w;
        int last;
        w = wr ? int'(WAIT_CLKS_DEF) : int'(WAIT_CLKS_DEF) + int'(READ_EXTRA_DEF);
        last = w + (burst ? 3 : 0);
        addr_status_n = 1'b0;
        wr_rd = wr;
        byte_enables_n = be;
        last_beat_n = burst;
        @(negedge core_clk);
        cmp_bit("ext_start", 1'b0, ext_cycle_start_n);
        cmp_bit("op_start", 1'b0, op_cycle_start_n);
        cmp_bit("strobe_gap", 1'b1, cpu_ctrl.addr_strobe_n);
        step();
        addr_status_n = 1'b1;
        for (int k = 0; k <= last; k++) begin
            @(negedge core_clk);
            cmp_bit("ready", k != last, ready_n);
            cmp_bit("burst_ready", !(burst && k >= w && k < last), burst_ready_n);
            cmp_bit("addr_strobe", 1'b0, cpu_ctrl.addr_strobe_n);
            cmp_bit("ready16", k != w, ready16_n);
            cmp_bit("burst16", 1'b1, burst16_n);
            if (k == w) begin
                cmp_bit("data_strobe", 1'b0, cpu_ctrl.data_strobe_n);
                cmp_bit("buf_en", 1'b0, cpu_ctrl.data_buf_en_n);
                cmp_bit("rd_wr", !wr, cpu_ctrl.rd_wr);
                cmp_fld("size", size, {cpu_ctrl.xfer_size1, cpu_ctrl.xfer_size0});
                cmp_fld("low_addr", addr, {cpu_ctrl.addr_bit1, cpu_ctrl.addr_bit0});
                cmp_fld("strobes16", be[1:0], {ctrl16.upper_byte_strobe_n, ctrl16.lower_byte_strobe_n});
                cmp_bit("a1_16", be[3], ctrl16.addr_bit1);
            end
            step();
            if (k == last - 1) last_beat_n = 1'b0;
        end
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (4) step();
        chk_idle();
        repeat (4) step();
        nrst = 1'b1;
        $display("test reset done");
        // both requesters at once: refresh must win, then precharge before the coprocessor
        refresh_req = 1'b1;
        hold_req = 1'b1;
        for (n = 0; n < 100 && refresh_cycle !== 1'b1 && hold_grant !== 1'b1; n++) step();
        cmp_bit("ack_held", 1'b0, grant_ack_n);
        cmp_bit("refresh_first", 1'b1, refresh_cycle);
        refresh_req = 1'b0;
        for (n = 0; n < 100 && refresh_cycle !== 1'b0; n++) step();
        for (n = 0; n < 100 && hold_grant !== 1'b1; n++) step();
        cmp_bit("precharge", 1'b1, n >= PRECHARGE_CLKS);
        $display("test priority done");
        foreach (rows[i]) xfer(rows[i].wr, rows[i].be, rows[i].size, rows[i].addr, 1'b0);
        $display("test single transfers done");
        xfer(1'b1, 4'h0, 2'h0, 2'h0, 1'b1);
        xfer(1'b0, 4'h0, 2'h0, 2'h0, 1'b1);
        $display("test bursts done");
        // refresh arriving in a coprocessor tenure waits for it to end
        refresh_req = 1'b1;
        repeat (10) step();
        cmp_bit("no_preempt", 1'b0, refresh_cycle);
        hold_req = 1'b0;
        for (n = 0; n < 100 && hold_grant !== 1'b0; n++) step();
        cmp_bit("req_kept", 1'b0, cpu_bus_req_n);
        for (n = 0; n < 100 && refresh_cycle !== 1'b1; n++) step();
        cmp_bit("precharge_2", 1'b1, n >= PRECHARGE_CLKS);
        refresh_req = 1'b0;
        for (n = 0; n < 100 && cpu_bus_req_n !== 1'b1; n++) step();
        for (n = 0; n < 100 && grant_ack_n !== 1'b1; n++) step();
        cmp_bit("ack_released", 1'b1, grant_ack_n);
        cmp_bit("grant_first", 1'b1, cpu_bus_grant_n);
        $display("test refresh in tenure done");
        // reset in the middle of a tenure
        hold_req = 1'b1;
        for (n = 0; n < 100 && hold_grant !== 1'b1; n++) step();
        nrst = 1'b0;
        hold_req = 1'b0;
        step();
        chk_idle();
        nrst = 1'b1;
        repeat (2) step();
        chk_idle();
        $display("test mid-run reset done");
        results();
    end
endmodule
